// ===== cpmc_analog.sv
`timescale 1ns/1ps
`default_nettype none
module cpmc_analog (
  // scenario controls
  input  wire logic          vin_on,
  input  wire logic          sel_pin,
  input  wire logic          ovl,
  input  wire logic          min_ok,
  // comparator levels
  output cpmc_pkg::cpmc_sense_t sense
);
  // source strength and battery overload set by the scenario
  assign sense = {vin_on, vin_on, !vin_on, 1'b1, min_ok, 1'b1, ovl,
                  1'b1, 1'b1, 1'b1, 1'b0, 1'b1, sel_pin, 1'b0};
endmodule : cpmc_analog
`default_nettype wire

// ===== cpmc_pkg.sv
package cpmc_pkg;

  // timing base
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned T_BIAS_REGULATOR_MS     = 220;
  localparam int unsigned T_BOOST_MS    = 30;
  localparam int unsigned T_RETRY_S     = 2;
  localparam int unsigned T_QUAL_US     = 10;
  localparam int unsigned T_BOOST_PFM_US = 100;
  localparam int unsigned T_SAFETY_H    = 10;
  localparam int unsigned BIAS_REGULATOR_DLY_CYC  = T_BIAS_REGULATOR_MS * (CLK_HZ / 1000);
  localparam int unsigned BOOST_DLY_CYC = T_BOOST_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_CYC     = T_RETRY_S * CLK_HZ;
  localparam int unsigned SEC_CYC       = CLK_HZ;
  localparam int unsigned QUAL_CYC      = T_QUAL_US * (CLK_HZ / 1_000_000);
  localparam int unsigned BOOST_PFM_CYC =
    T_BOOST_PFM_US * (CLK_HZ / 1_000_000);
  localparam int unsigned SAFETY_SEC    = T_SAFETY_H * 3600;
  localparam int unsigned WD_SEC_1      = 40;
  localparam int unsigned WD_SEC_2      = 80;
  localparam int unsigned WD_SEC_3      = 160;

  // register byte addresses
  localparam logic [11:0] A_LIMIT  = 12'h000;
  localparam logic [11:0] A_CTRL   = 12'h004;
  localparam logic [11:0] A_STATUS = 12'h008;

  // limit register fields
  localparam int F_ILIM  = 0;
  localparam int F_VLIM  = 8;
  localparam int F_TRACK = 12;
  // control register fields
  localparam int F_CHG_EN   = 0;
  localparam int F_PSK_DIS  = 1;
  localparam int F_BOOST_OE = 2;
  localparam int F_BOOST_CURRENT_LIMIT_SEL = 3;
  localparam int F_DET_REQ  = 4;
  localparam int F_KEEP     = 5;
  localparam int F_WD_PER   = 6;
  localparam int F_BSW_OFF  = 8;
  localparam int F_BSW_RSTE = 9;
  localparam int F_BSW_DLY  = 10;
  // status register fields
  localparam int F_IN_GOOD  = 0;
  localparam int F_PG       = 1;
  localparam int F_TYPE     = 2;
  localparam int F_WD_FLAG  = 5;
  localparam int F_HIZ      = 6;
  localparam int F_SAFE_FLT = 7;
  localparam int F_BOOST_ON = 8;
  localparam int F_CONV_ON  = 9;

  // reset values and codes
  localparam logic [4:0]  ILIM_RST   = 5'h04;
  localparam logic [4:0]  ILIM_USB   = 5'h04;
  localparam logic [4:0]  ILIM_ADP   = 5'h17;
  localparam logic [4:0]  ILIM_SOFT  = 5'h01;
  localparam logic [3:0]  VLIM_RST   = 4'h6;
  localparam logic [12:0] VLIM_BASE_MV = 13'h0f3c;
  localparam logic [12:0] VLIM_STEP_MV = 13'h0064;
  localparam logic [12:0] TRK_OFS1_MV  = 13'h00c8;
  localparam logic [12:0] TRK_OFS2_MV  = 13'h00fa;
  localparam logic [12:0] TRK_OFS3_MV  = 13'h012c;
  localparam logic [12:0] BOOST_MV     = 13'h141e;
  localparam logic [1:0]  WD_PER_RST   = 2'h1;
  localparam logic [2:0]  TYPE_NONE  = 3'h0;
  localparam logic [2:0]  TYPE_USB   = 3'h1;
  localparam logic [2:0]  TYPE_ADP   = 3'h3;
  localparam logic [2:0]  TYPE_BOOST = 3'h7;

  typedef enum logic [3:0] {
    ST_HIZ, ST_BIAS_REGULATOR_WAIT, ST_QUAL, ST_RETRY, ST_DETECT,
    ST_VLIMIT, ST_RUN, ST_BOOST_WAIT, ST_BOOST
  } cpmc_state_t;

  // comparator and pin levels from the analog side
  typedef struct packed {
    logic vac_present;
    logic vac_above_sleepz;
    logic vbus_in_sleep;
    logic vbus_below_ov;
    logic vbus_above_min;
    logic bat_above_depl;
    logic bat_overload;
    logic bat_above_boost;
    logic sys_above_2v2;
    logic sys_above_min;
    logic light_load;
    logic ts_in_window;
    logic source_select_pin;
    logic charge_disable_pin;
  } cpmc_sense_t;

  // controls to the power stage
  typedef struct packed {
    logic        bias_regulator_en;
    logic        test_load_en;
    logic        buck_en;
    logic        buck_pulse_skip;
    logic        boost_en;
    logic        boost_pulse_skip;
    logic        boost_ilim_high;
    logic        battery_switch_on;
    logic        charge_en;
    logic        host_interrupt;
    logic        host_timeout_flag;
    logic [4:0]  iin_limit_code;
    logic [12:0] vin_limit_mv;
    logic [12:0] boost_vreg_mv;
  } cpmc_drive_t;

endpackage : cpmc_pkg

// ===== cpmc_props.sv
`timescale 1ns/1ps
`default_nettype none
module cpmc_props (
  // apb
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // power stage
  input wire cpmc_pkg::cpmc_drive_t drive
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held");
  a_unmapped_err: assert property (pready && paddr > 12'h008
    |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
  a_buck_order: assert property (drive.buck_en
    |-> drive.bias_regulator_en) else $error("buck without bias");
  a_boost_sleep: assert property (drive.boost_en
    |-> !drive.bias_regulator_en) else $error("boost with input");
  a_boost_volt: assert property (drive.boost_en
    |-> drive.boost_vreg_mv == cpmc_pkg::BOOST_MV) else $error("boost vreg");
  a_irq_pulse: assert property (drive.host_interrupt
    |=> !drive.host_interrupt) else $error("interrupt not a pulse");
  a_boost_skip: assert property ($rose(drive.boost_en)
    |-> drive.boost_pulse_skip) else $error("boost not skipping");
endmodule : cpmc_props
bind cpmc_top cpmc_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .drive(drive));
`default_nettype wire

// ===== cpmc_top.sv
// Contract
// - on supply power-on reset all registers take defaults; bus usable.
// - battery only, above depletion: battery switch closed, bias regulator off.
// - battery overload opens switch, sets battery_switch_off until input/host re-enable.
// - input start order: bias, qualify, detect, voltage limit, converter.
// - bias on only with input present, above sleep, after 220 ms.
// - converter start needs input below overvoltage and above minimum under load.
// - qualification pass sets input_good and pulses host_interrupt.
// - failed qualification repeats every 2 s.
// - detection done: interrupt, load limit, power_good_flag, input_type_code.
// - select pin high 500 mA code 001; low 2.4 A code 011.
// - default mode tracks pin; host mode samples on current_detect_request.
// - voltage limit 4.5 V default; tracking takes max with battery plus offset.
// - converter starts after limit; switch closed only when charging enabled.
// - system below 2.2 V caps input at min of 200 mA and limit.
// - fixed-frequency buck; pulse skipping at light load unless disabled.
// - boost needs battery, sleep, enable bit, thermistor window, 30 ms.
// - boost reports type 111, 5.15 V target, limit from select bit.
// - boost starts pulse skipping then fixed frequency; held while battery ok.
// - host_timeout_flag high in default mode; default mode after reset.
// - default mode charging stops after 10 hours; buck keeps running.
// - keepalive write enters host mode; period 00 disables the watchdog.
// - watchdog expiry: default mode, registers reset except current/voltage limit codes and battery switch bits; tracking cleared.
`timescale 1ns/1ps
`default_nettype none

module cpmc_top #(
  parameter int unsigned BIAS_REGULATOR_DLY_CYC  = cpmc_pkg::BIAS_REGULATOR_DLY_CYC,
  parameter int unsigned BOOST_DLY_CYC = cpmc_pkg::BOOST_DLY_CYC,
  parameter int unsigned RETRY_CYC     = cpmc_pkg::RETRY_CYC,
  parameter int unsigned SEC_CYC       = cpmc_pkg::SEC_CYC
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // analog side
  input  wire cpmc_pkg::cpmc_sense_t sense_raw,
  input  wire logic [12:0]           bat_mv,
  output cpmc_pkg::cpmc_drive_t      drive
);

  localparam int NS = $bits(cpmc_pkg::cpmc_sense_t);

  logic [NS-1:0]         sync1;
  logic [NS-1:0]         sync2;
  cpmc_pkg::cpmc_sense_t sn;
  logic                  vac_prev;

  // two-stage synchroniser per sensed level
  genvar gi;
  generate
    for (gi = 0; gi < NS; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
        end else begin
          sync1[gi] <= sense_raw[gi];
          sync2[gi] <= sync1[gi];
        end
      end
    end
  endgenerate
  assign sn = cpmc_pkg::cpmc_sense_t'(sync2);

  function automatic logic [1:0] reg_index(input logic [11:0] a);
    case (a)
      cpmc_pkg::A_LIMIT:  reg_index = 2'h1;
      cpmc_pkg::A_CTRL:   reg_index = 2'h2;
      cpmc_pkg::A_STATUS: reg_index = 2'h3;
      default:            reg_index = 2'h0;
    endcase
  endfunction : reg_index

  // registers
  logic [4:0]  ilim;
  logic [3:0]  vlim;
  logic [1:0]  track;
  logic        chg_en;
  logic        psk_dis;
  logic        boost_oe;
  logic        boost_current_limit_sel;
  logic        det_req;
  logic [1:0]  wd_per;
  logic        bsw_off;
  logic        bsw_rst_en;
  logic        bsw_dly;
  // status and sequencing
  cpmc_pkg::cpmc_state_t state;
  logic [31:0] dly;
  logic        input_good;
  logic        pg;
  logic [2:0]  type_code;
  logic        irq;
  logic        host_mode;
  logic        wd_expire;
  logic [31:0] wd_cyc;
  logic [7:0]  wd_sec;
  logic        safety_fault;
  logic [31:0] sf_cyc;
  logic [15:0] sf_sec;
  logic [31:0] pfm_cnt;

  logic        wr;
  logic        wr_limit;
  logic        wr_ctrl;
  logic        keepalive;
  logic        buck_ok;
  logic        boost_ok;
  logic        charging;
  logic        pin_ilim_sel;
  logic [4:0]  pin_ilim;
  logic [31:0] rdata;
  logic [12:0] reg_mv;
  logic [12:0] trk_mv;
  logic [7:0]  wd_limit;

  assign wr        = psel & penable & pready & pwrite;
  assign wr_limit  = wr & (reg_index(paddr) == 2'h1);
  assign wr_ctrl   = wr & (reg_index(paddr) == 2'h2);
  assign keepalive = wr_ctrl & pwdata[cpmc_pkg::F_KEEP];
  assign buck_ok   = sn.vac_present & sn.vac_above_sleepz;
  assign boost_ok  = !sn.vac_present & sn.vbus_in_sleep & boost_oe
                   & sn.bat_above_boost & sn.ts_in_window;
  assign charging  = chg_en & !sn.charge_disable_pin & !bsw_off
                   & !safety_fault;
  assign pin_ilim_sel = sn.source_select_pin;
  assign pin_ilim  = pin_ilim_sel ? cpmc_pkg::ILIM_USB
                                  : cpmc_pkg::ILIM_ADP;

  // apb: answer in the access cycle, read data captured at setup
  always_comb begin
    rdata = 32'h0;
    case (reg_index(paddr))
      2'h1: begin
        rdata[cpmc_pkg::F_ILIM +: 5]  = ilim;
        rdata[cpmc_pkg::F_VLIM +: 4]  = vlim;
        rdata[cpmc_pkg::F_TRACK +: 2] = track;
      end
      2'h2: begin
        rdata[cpmc_pkg::F_CHG_EN]     = chg_en;
        rdata[cpmc_pkg::F_PSK_DIS]    = psk_dis;
        rdata[cpmc_pkg::F_BOOST_OE]   = boost_oe;
        rdata[cpmc_pkg::F_BOOST_CURRENT_LIMIT_SEL]  = boost_current_limit_sel;
        rdata[cpmc_pkg::F_DET_REQ]    = det_req;
        rdata[cpmc_pkg::F_WD_PER +: 2] = wd_per;
        rdata[cpmc_pkg::F_BSW_OFF]    = bsw_off;
        rdata[cpmc_pkg::F_BSW_RSTE]   = bsw_rst_en;
        rdata[cpmc_pkg::F_BSW_DLY]    = bsw_dly;
      end
      2'h3: begin
        rdata[cpmc_pkg::F_IN_GOOD]    = input_good;
        rdata[cpmc_pkg::F_PG]         = pg;
        rdata[cpmc_pkg::F_TYPE +: 3]  = type_code;
        rdata[cpmc_pkg::F_WD_FLAG]    = !host_mode;
        rdata[cpmc_pkg::F_HIZ]        = (state == cpmc_pkg::ST_HIZ);
        rdata[cpmc_pkg::F_SAFE_FLT]   = safety_fault;
        rdata[cpmc_pkg::F_BOOST_ON]   = (state == cpmc_pkg::ST_BOOST);
        rdata[cpmc_pkg::F_CONV_ON]    = (state == cpmc_pkg::ST_RUN);
      end
      default: rdata = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end else begin
      pready  <= psel & !penable;
      pslverr <= psel & !penable & (reg_index(paddr) == 2'h0);
      if (psel & !penable) begin
        prdata <= pwrite ? 32'h0 : rdata;
      end
    end
  end

  // input current limit: kept across watchdog expiry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilim <= cpmc_pkg::ILIM_RST;
    end else if (wr_limit) begin
      ilim <= pwdata[cpmc_pkg::F_ILIM +: 5];
    end else if (state == cpmc_pkg::ST_DETECT && dly == 32'h1) begin
      ilim <= pin_ilim;
    end else if (pg && !host_mode) begin
      ilim <= pin_ilim;
    end else if (pg && det_req) begin
      ilim <= pin_ilim;
    end
  end

  // input voltage limit and tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlim  <= cpmc_pkg::VLIM_RST;
      track <= 2'h0;
    end else if (wr_limit) begin
      vlim  <= pwdata[cpmc_pkg::F_VLIM +: 4];
      track <= pwdata[cpmc_pkg::F_TRACK +: 2];
    end else if (wd_expire) begin
      track <= 2'h0;
    end
  end

  // control bits; expiry spares the battery switch bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chg_en     <= 1'b1;
      psk_dis    <= 1'b0;
      boost_oe   <= 1'b0;
      boost_current_limit_sel  <= 1'b0;
      det_req    <= 1'b0;
      wd_per     <= cpmc_pkg::WD_PER_RST;
      bsw_rst_en <= 1'b1;
      bsw_dly    <= 1'b0;
    end else if (wd_expire) begin
      chg_en    <= 1'b1;
      psk_dis   <= 1'b0;
      boost_oe  <= 1'b0;
      boost_current_limit_sel <= 1'b0;
      det_req   <= 1'b0;
      wd_per    <= cpmc_pkg::WD_PER_RST;
    end else if (wr_ctrl) begin
      chg_en     <= pwdata[cpmc_pkg::F_CHG_EN];
      psk_dis    <= pwdata[cpmc_pkg::F_PSK_DIS];
      boost_oe   <= pwdata[cpmc_pkg::F_BOOST_OE];
      boost_current_limit_sel  <= pwdata[cpmc_pkg::F_BOOST_CURRENT_LIMIT_SEL];
      det_req    <= pwdata[cpmc_pkg::F_DET_REQ] | det_req;
      wd_per     <= pwdata[cpmc_pkg::F_WD_PER +: 2];
      bsw_rst_en <= pwdata[cpmc_pkg::F_BSW_RSTE];
      bsw_dly    <= pwdata[cpmc_pkg::F_BSW_DLY];
    end else if (pg && det_req) begin
      det_req <= 1'b0;
    end
  end

  // battery switch disable: overload wins over any clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsw_off  <= 1'b0;
      vac_prev <= 1'b0;
    end else begin
      vac_prev <= sn.vac_present;
      if (sn.bat_overload) begin
        bsw_off <= 1'b1;
      end else if (sn.vac_present && !vac_prev) begin
        bsw_off <= 1'b0;
      end else if (wr_ctrl) begin
        bsw_off <= pwdata[cpmc_pkg::F_BSW_OFF];
      end
    end
  end

  // watchdog: keepalive beats expiry in the same cycle
  always_comb begin
    case (wd_per)
      2'h1:    wd_limit = 8'(cpmc_pkg::WD_SEC_1);
      2'h2:    wd_limit = 8'(cpmc_pkg::WD_SEC_2);
      2'h3:    wd_limit = 8'(cpmc_pkg::WD_SEC_3);
      default: wd_limit = 8'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_mode <= 1'b0;
      wd_expire <= 1'b0;
      wd_cyc    <= 32'h0;
      wd_sec    <= 8'h0;
    end else begin
      wd_expire <= 1'b0;
      if (keepalive) begin
        host_mode <= 1'b1;
        wd_cyc    <= 32'h0;
        wd_sec    <= 8'h0;
      end else if (host_mode && wd_per != 2'h0) begin
        if (wd_cyc == SEC_CYC - 1) begin
          wd_cyc <= 32'h0;
          if (wd_sec == wd_limit - 8'h1) begin
            wd_sec    <= 8'h0;
            host_mode <= 1'b0;
            wd_expire <= 1'b1;
          end else begin
            wd_sec <= wd_sec + 8'h1;
          end
        end else begin
          wd_cyc <= wd_cyc + 32'h1;
        end
      end else begin
        wd_cyc <= 32'h0;
        wd_sec <= 8'h0;
      end
    end
  end

  // fast-charge safety timer, default mode only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      safety_fault <= 1'b0;
      sf_cyc       <= 32'h0;
      sf_sec       <= 16'h0;
    end else if (state != cpmc_pkg::ST_RUN || !chg_en) begin
      safety_fault <= 1'b0;
      sf_cyc       <= 32'h0;
      sf_sec       <= 16'h0;
    end else if (!host_mode && charging) begin
      if (sf_cyc == SEC_CYC - 1) begin
        sf_cyc <= 32'h0;
        if (sf_sec == 16'(cpmc_pkg::SAFETY_SEC - 1)) begin
          safety_fault <= 1'b1;
        end else begin
          sf_sec <= sf_sec + 16'h1;
        end
      end else begin
        sf_cyc <= sf_cyc + 32'h1;
      end
    end
  end

  // power-up sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= cpmc_pkg::ST_HIZ;
      dly        <= 32'h0;
      input_good <= 1'b0;
      pg         <= 1'b0;
      type_code  <= cpmc_pkg::TYPE_NONE;
      irq        <= 1'b0;
    end else begin
      irq <= 1'b0;
      dly <= dly + 32'h1;
      case (state)
        cpmc_pkg::ST_HIZ: begin
          dly        <= 32'h0;
          input_good <= 1'b0;
          pg         <= 1'b0;
          type_code  <= cpmc_pkg::TYPE_NONE;
          if (buck_ok) begin
            state <= cpmc_pkg::ST_BIAS_REGULATOR_WAIT;
          end else if (boost_ok) begin
            state <= cpmc_pkg::ST_BOOST_WAIT;
          end
        end
        cpmc_pkg::ST_BIAS_REGULATOR_WAIT: begin
          if (!buck_ok) begin
            state <= cpmc_pkg::ST_HIZ;
          end else if (dly == BIAS_REGULATOR_DLY_CYC - 1) begin
            state <= cpmc_pkg::ST_QUAL;
            dly   <= 32'h0;
          end
        end
        cpmc_pkg::ST_QUAL: begin
          if (!buck_ok) begin
            state <= cpmc_pkg::ST_HIZ;
          end else if (dly == cpmc_pkg::QUAL_CYC - 1) begin
            dly <= 32'h0;
            if (sn.vbus_below_ov && sn.vbus_above_min) begin
              state      <= cpmc_pkg::ST_DETECT;
              input_good <= 1'b1;
              irq        <= 1'b1;
            end else begin
              state <= cpmc_pkg::ST_RETRY;
            end
          end
        end
        cpmc_pkg::ST_RETRY: begin
          if (!buck_ok) begin
            state <= cpmc_pkg::ST_HIZ;
          end else if (dly == RETRY_CYC - 1) begin
            state <= cpmc_pkg::ST_QUAL;
            dly   <= 32'h0;
          end
        end
        cpmc_pkg::ST_DETECT: begin
          if (!buck_ok) begin
            state <= cpmc_pkg::ST_HIZ;
          end else if (dly == 32'h1) begin
            state     <= cpmc_pkg::ST_VLIMIT;
            irq       <= 1'b1;
            pg        <= 1'b1;
            type_code <= pin_ilim_sel ? cpmc_pkg::TYPE_USB
                                      : cpmc_pkg::TYPE_ADP;
          end
        end
        cpmc_pkg::ST_VLIMIT: begin
          state <= buck_ok ? cpmc_pkg::ST_RUN : cpmc_pkg::ST_HIZ;
        end
        cpmc_pkg::ST_RUN: begin
          if (!buck_ok) begin
            state <= cpmc_pkg::ST_HIZ;
          end
        end
        cpmc_pkg::ST_BOOST_WAIT: begin
          if (!boost_ok) begin
            state <= cpmc_pkg::ST_HIZ;
          end else if (dly == BOOST_DLY_CYC - 1) begin
            state     <= cpmc_pkg::ST_BOOST;
            type_code <= cpmc_pkg::TYPE_BOOST;
          end
        end
        cpmc_pkg::ST_BOOST: begin
          if (!boost_ok) begin
            state <= cpmc_pkg::ST_HIZ;
          end
        end
        default: state <= cpmc_pkg::ST_HIZ;
      endcase
    end
  end

  // boost soft start in pulse skipping
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pfm_cnt <= 32'h0;
    end else if (state != cpmc_pkg::ST_BOOST) begin
      pfm_cnt <= 32'h0;
    end else if (pfm_cnt != cpmc_pkg::BOOST_PFM_CYC) begin
      pfm_cnt <= pfm_cnt + 32'h1;
    end
  end

  // effective input voltage limit
  always_comb begin
    reg_mv = cpmc_pkg::VLIM_BASE_MV
           + 13'(vlim * cpmc_pkg::VLIM_STEP_MV);
    case (track)
      2'h1:    trk_mv = bat_mv + cpmc_pkg::TRK_OFS1_MV;
      2'h2:    trk_mv = bat_mv + cpmc_pkg::TRK_OFS2_MV;
      2'h3:    trk_mv = bat_mv + cpmc_pkg::TRK_OFS3_MV;
      default: trk_mv = 13'h0;
    endcase
  end

  // registered drive to the power stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive <= '0;
      drive.host_timeout_flag <= 1'b1;
      drive.vin_limit_mv      <= 13'h1194;
      drive.iin_limit_code    <= cpmc_pkg::ILIM_SOFT;
    end else begin
      drive.bias_regulator_en <= state != cpmc_pkg::ST_HIZ
        && state != cpmc_pkg::ST_BIAS_REGULATOR_WAIT
        && state != cpmc_pkg::ST_BOOST_WAIT
        && state != cpmc_pkg::ST_BOOST;
      drive.test_load_en <= state == cpmc_pkg::ST_QUAL;
      drive.buck_en      <= state == cpmc_pkg::ST_RUN;
      drive.buck_pulse_skip <= state == cpmc_pkg::ST_RUN && !psk_dis
        && (sn.light_load || !sn.sys_above_min || !charging);
      drive.boost_en <= state == cpmc_pkg::ST_BOOST;
      drive.boost_pulse_skip <= state == cpmc_pkg::ST_BOOST && !psk_dis
        && pfm_cnt != cpmc_pkg::BOOST_PFM_CYC;
      drive.boost_ilim_high <= boost_current_limit_sel;
      drive.boost_vreg_mv <= (state == cpmc_pkg::ST_BOOST)
        ? cpmc_pkg::BOOST_MV : 13'h0;
      if (bsw_off || sn.bat_overload) begin
        drive.battery_switch_on <= 1'b0;
      end else if (state == cpmc_pkg::ST_RUN) begin
        drive.battery_switch_on <= charging;
      end else begin
        drive.battery_switch_on <= sn.bat_above_depl;
      end
      drive.charge_en <= state == cpmc_pkg::ST_RUN && charging;
      drive.host_interrupt    <= irq;
      drive.host_timeout_flag <= !host_mode;
      drive.vin_limit_mv <= (trk_mv > reg_mv) ? trk_mv : reg_mv;
      if (state == cpmc_pkg::ST_RUN && !sn.sys_above_2v2
          && ilim > cpmc_pkg::ILIM_SOFT) begin
        drive.iin_limit_code <= cpmc_pkg::ILIM_SOFT;
      end else begin
        drive.iin_limit_code <= ilim;
      end
    end
  end

endmodule : cpmc_top

`default_nettype wire

// ===== test_charger_powerup_mode_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_charger_powerup_mode_control;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, err_seen, vin_on = 0, sel_pin = 0;
  logic ovl = 0, min_ok = 1;
  logic [12:0] bat_mv = 13'h0e74;
  cpmc_pkg::cpmc_sense_t sense;
  cpmc_pkg::cpmc_drive_t drive;
  int err_total = 0, checks = 0, cyc = 0, c;
  always #50 pclk = ~pclk;
  cpmc_analog far (.vin_on(vin_on), .sel_pin(sel_pin), .ovl(ovl),
    .min_ok(min_ok), .sense(sense));
  cpmc_top #(.BIAS_REGULATOR_DLY_CYC(20), .RETRY_CYC(50), .BOOST_DLY_CYC(10),
    .SEC_CYC(20)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sense_raw(sense), .bat_mv(bat_mv), .drive(drive));
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  task automatic cmp(string n, logic [31:0] e, logic [31:0] s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask : cmp
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata; err_seen = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask : xfer
  task automatic rd(logic [11:0] a, logic [31:0] m, logic [31:0] e,
                    string n);
    xfer(0, a, 32'h0);
    cmp(n, e, q & m);
  endtask : rd
  task automatic wait_on(logic buck);
    c = 0;
    while ((buck ? drive.buck_en : drive.boost_en) !== 1'b1) begin
      @(posedge pclk);
      c++;
    end
  endtask : wait_on
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    rd(12'h000, '1, 32'h604, "limit");
    rd(12'h004, '1, 32'h241, "control");
    rd(12'h00c, '1, 32'h0, "unmapped");
    cmp("slverr", 1, err_seen);
    cmp("default", 1, drive.host_timeout_flag);
    cmp("vlim_rst", 13'h1194, drive.vin_limit_mv);
    cmp("bat_only", 2'b10, {drive.battery_switch_on,
                            drive.bias_regulator_en});
    $display("test reset done");
    xfer(1, 12'h004, 32'h245);
    wait_on(0);
    cmp("boost_dly", 1, c >= 10);
    cmp("boost_psk", 1, drive.boost_pulse_skip);
    rd(12'h008, 32'h1c, 32'h1c, "boost_type");
    xfer(1, 12'h004, 32'h241);
    $display("test boost done");
    ovl <= 1;
    repeat (4) @(posedge pclk);
    cmp("ovl_off", 0, drive.battery_switch_on);
    ovl <= 0;
    rd(12'h004, 32'h100, 32'h100, "ovl_flag");
    $display("test overload done");
    vin_on <= 1;
    wait_on(1);
    cmp("start_dly", 1, c >= 120);
    rd(12'h008, 32'h1f, 32'h0f, "status");
    cmp("adp_lim", 5'h17, drive.iin_limit_code);
    cmp("bsw_chg", 1, drive.battery_switch_on);
    sel_pin <= 1;
    repeat (6) @(posedge pclk);
    cmp("usb_lim", 5'h04, drive.iin_limit_code);
    rd(12'h008, 32'h1c, 32'h0c, "type_kept");
    vin_on <= 0;
    min_ok <= 0;
    repeat (8) @(posedge pclk);
    vin_on <= 1;
    repeat (300) @(posedge pclk);
    rd(12'h008, 32'h1, 32'h0, "poor_src");
    min_ok <= 1;
    wait_on(1);
    cmp("retry", 1, c <= 170);
    rd(12'h008, 32'h1c, 32'h04, "usb_type");
    $display("test input done");
    xfer(1, 12'h004, 32'h669);
    repeat (3) @(posedge pclk);
    cmp("host_mode", 0, drive.host_timeout_flag);
    rd(12'h004, '1, 32'h649, "host_ctrl");
    xfer(1, 12'h000, 32'h1704);
    bat_mv <= 13'h1194;
    repeat (3) @(posedge pclk);
    cmp("vlim_trk", 13'h125c, drive.vin_limit_mv);
    $display("test keepalive done");
    repeat (800) @(posedge pclk);
    cmp("wd_expired", 1, drive.host_timeout_flag);
    rd(12'h000, '1, 32'h704, "kept_limit");
    rd(12'h004, '1, 32'h641, "ctrl_reset");
    cmp("vlim_kept", 13'h11f8, drive.vin_limit_mv);
    $display("test watchdog done");
    test_done();
  end
endmodule : test_charger_powerup_mode_control
`default_nettype wire
